// ---- hdl/vhb_pkg.sv ----
package vhb_pkg;

    localparam int          VHB_MAX_TAGS   = 8;
    localparam logic [3:0]  VHB_PING_TAGS  = 4'h2;
    localparam logic [3:0]  VHB_FULL_TAGS  = 4'h8;

    // Register byte offsets
    localparam logic [5:0]  OFS_CTRL       = 6'h00;
    localparam logic [5:0]  OFS_STATUS     = 6'h04;
    localparam logic [5:0]  OFS_TYPE       = 6'h08;
    localparam logic [5:0]  OFS_IPA        = 6'h0C;
    localparam logic [5:0]  OFS_IPB        = 6'h10;
    localparam logic [5:0]  OFS_VLAN0      = 6'h20;

    // Control field positions
    localparam int          CTRL_START     = 0;
    localparam int          CTRL_PING      = 1;
    localparam int          CTRL_LLC       = 2;
    localparam int          CTRL_SNAP      = 3;
    localparam int          CTRL_L3_LSB    = 4;
    localparam int          CTRL_IDINC     = 6;
    localparam int          CTRL_CNT_LSB   = 8;

    // Reset values
    localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
    localparam logic [15:0] TYPE_RST       = 16'h88B5;
    localparam logic [31:0] IPA_RST        = 32'h0000_0000;
    localparam logic [31:0] IPB_RST        = 32'hFD20_0026;
    localparam logic [17:0] VLAN_RST       = 18'h0_0000;

    // Header codes
    localparam logic [15:0] TPID_8100      = 16'h8100;
    localparam logic [15:0] TPID_88A8      = 16'h88A8;
    localparam logic [15:0] TPID_9100      = 16'h9100;
    localparam logic [15:0] TPID_9200      = 16'h9200;
    localparam logic [15:0] ETYPE_IPV4     = 16'h0800;
    localparam logic [15:0] ETYPE_IPV6     = 16'h86DD;
    localparam logic [15:0] TYPE_MIN       = 16'h05DD;
    localparam logic [7:0]  IP_VER_IHL     = 8'h45;
    localparam logic [15:0] IP_HDR_BYTES   = 16'h0014;
    localparam logic [15:0] LLC_BYTES      = 16'h0003;
    localparam logic [15:0] SNAP_BYTES     = 16'h0005;
    localparam logic [7:0]  SAP_SNAP       = 8'hAA;
    localparam logic [7:0]  SAP_IPV4       = 8'h06;
    localparam logic [7:0]  SAP_OTHER      = 8'h42;
    localparam logic [7:0]  LLC_CTRL_UI    = 8'h03;

    typedef enum logic [1:0] {L3_NONE, L3_IPV4, L3_IPV6, L3_BAD} vhb_l3_type;

    typedef enum logic [2:0] {ST_IDLE, ST_VLAN, ST_LLC, ST_SNAP, ST_IP} vhb_state_type;

    typedef struct packed {
        logic [1:0]  tpid_sel;
        logic        dei;
        logic [2:0]  pcp;
        logic [11:0] vid;
    } vhb_tag_type;

    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } vhb_beat_type;

endpackage

// ---- hdl/vhb_header_builder.sv ----
// Functional notes
// - One to eight tags, each configured separately
// - Ping mode caps tag depth at two
// - Two tags: outer service, inner customer
// - Each tag: identifier, priority, one flag
// - Stacked tag types from four TPIDs
// - IPv4/IPv6 set innermost type automatically
// - No network layer: type 0x05DD..0xFFFF
// - LLC1 saps and control from upper layer
// - SNAP protocol id zero, then type
// - SNAP without LLC1 is rejected
// - IPv4 version 4, header length five
// - IPv4 type of service configurable
// - Total length computed, not entered
// - Auto increment changes identification per frame
// - Each tag adds control and type fields
// - Tagging on: receiver accepts tagged only
//
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module vhb_fifo
    import vhb_pkg::*;
#(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
)(
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      count_ff;
    logic             out_valid_ff;
    logic [WIDTH-1:0] out_data_ff;

    wire push = in_valid && in_ready;
    // Output register reloads when the buffer holds a beat and the register is empty or being drained
    wire pop  = (count_ff != '0) && (!out_valid_ff || out_ready);
    wire [AW:0] nxt_count = count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    assign in_ready  = (count_ff != DEPTH[AW:0]);
    assign out_valid = out_valid_ff;
    assign out_data  = out_data_ff;

    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            wr_ptr_ff    <= '0;
            rd_ptr_ff    <= '0;
            count_ff     <= '0;
            out_valid_ff <= 1'b0;
            out_data_ff  <= '0;
        end
        else
        begin
            wr_ptr_ff <= push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
            rd_ptr_ff <= pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
            count_ff  <= nxt_count;
            if (pop)
            begin
                out_data_ff  <= mem[rd_ptr_ff];
                out_valid_ff <= 1'b1;
            end
            else if (out_ready)
            begin
                out_valid_ff <= 1'b0;
            end
        end
    end
endmodule // vhb_fifo

module vhb_header_builder
    import vhb_pkg::*;
#(
    parameter int FIFO_DEPTH = 32
)(
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic [7:0]       tx_data,
    output logic             tx_last,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic [15:0]      first_tpid,
    output logic             rx_tagged_only,
    output logic             hdr_busy
);
    logic [31:0]   ctrl_ff;
    logic [15:0]   type_ff;
    logic [31:0]   ipa_ff;
    logic [31:0]   ipb_ff;
    logic [17:0]   vlan_ff [VHB_MAX_TAGS];
    logic          wait_ff;
    logic [31:0]   rdata_ff;
    logic          start_pend_ff;
    logic          start_rej_ff;
    vhb_state_type st_ff;
    vhb_state_type nxt_st;
    vhb_state_type next_sec;
    logic [4:0]    idx_ff;
    logic [4:0]    nxt_idx;
    logic [2:0]    tag_ff;
    logic [2:0]    nxt_tag;
    logic [15:0]   id_ff;
    logic [15:0]   total_ff;
    logic [15:0]   first_tpid_ff;
    logic          tagged_only_ff;
    logic          busy_ff;
    logic          fifo_in_ready;
    vhb_beat_type  fifo_out;

    // Bus decode
    wire [5:0]  byte_addr = {avs_address, 2'b00};
    wire        sel_vlan  = byte_addr[5];
    wire [2:0]  vidx      = byte_addr[4:2];
    wire        req       = avs_read || avs_write;
    wire        wr_go     = avs_write && !wait_ff;
    wire        busy      = (st_ff != ST_IDLE);
    // Config is frozen while a header is being emitted
    wire        cfg_wr    = wr_go && !busy;
    wire [31:0] be_mask   = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                             {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire [31:0] wd_m      = avs_writedata & be_mask;
    wire        start_req = cfg_wr && (byte_addr == OFS_CTRL) && wd_m[CTRL_START];

    // Configuration view
    wire             cfg_ping  = ctrl_ff[CTRL_PING];
    wire             cfg_llc   = ctrl_ff[CTRL_LLC];
    wire             cfg_snap  = ctrl_ff[CTRL_SNAP];
    wire             cfg_idinc = ctrl_ff[CTRL_IDINC];
    wire vhb_l3_type cfg_l3    = vhb_l3_type'(ctrl_ff[CTRL_L3_LSB +: 2]);
    wire [3:0]       raw_cnt   = ctrl_ff[CTRL_CNT_LSB +: 4];
    wire [3:0]       cnt_cap   = cfg_ping ? VHB_PING_TAGS : VHB_FULL_TAGS;
    wire [3:0]       eff_cnt   = (raw_cnt > cnt_cap) ? cnt_cap : raw_cnt;
    wire [2:0]       last_tag  = (eff_cnt == 4'h0) ? 3'h0 : 3'(eff_cnt - 4'h1);
    wire             is_ip4    = (cfg_l3 == L3_IPV4);
    wire             is_ip6    = (cfg_l3 == L3_IPV6);
    wire             snap_bad  = cfg_snap && !cfg_llc;
    wire             type_bad  = (cfg_l3 == L3_NONE) && !cfg_llc && (type_ff < TYPE_MIN);
    wire             cfg_err   = snap_bad || type_bad || (cfg_l3 == L3_BAD);
    wire             go        = start_pend_ff && !cfg_err && !busy;

    // Lengths and type codes
    wire [15:0] ip_total  = 16'(IP_HDR_BYTES + ipb_ff[15:0]);
    wire [15:0] l3_len    = is_ip4 ? total_ff : ipb_ff[15:0];
    wire [15:0] llc_len   = 16'(LLC_BYTES + (cfg_snap ? SNAP_BYTES : 16'h0000) + l3_len);
    wire [15:0] l3_type   = is_ip4 ? ETYPE_IPV4 : (is_ip6 ? ETYPE_IPV6 : type_ff);
    // With LLC the innermost type carries the 802.3 length instead
    wire [15:0] inner_type = cfg_llc ? llc_len : l3_type;

    // VLAN tag bytes
    wire vhb_tag_type tag_cur = vhb_tag_type'(vlan_ff[tag_ff]);
    wire [15:0] tpid_sel_v = (tag_cur.tpid_sel == 2'h0) ? TPID_8100 :
                             (tag_cur.tpid_sel == 2'h1) ? TPID_88A8 :
                             (tag_cur.tpid_sel == 2'h2) ? TPID_9100 : TPID_9200;
    // Between service and customer tag the customer TPID is mandatory
    wire [15:0] stack_type = (eff_cnt == 4'h2) ? TPID_8100 : tpid_sel_v;
    wire [15:0] vlan_type  = (tag_ff == last_tag) ? inner_type : stack_type;
    wire [31:0] vlan_word  = {tag_cur.pcp, tag_cur.dei, tag_cur.vid, vlan_type};
    wire [7:0]  vlan_byte  = vlan_word[8*(3 - idx_ff[1:0]) +: 8];

    // LLC1 and SNAP bytes
    wire [7:0]  sap       = cfg_snap ? SAP_SNAP : (is_ip4 ? SAP_IPV4 : SAP_OTHER);
    wire [23:0] llc_word  = {sap, sap, LLC_CTRL_UI};
    wire [7:0]  llc_byte  = llc_word[8*(2 - idx_ff[1:0]) +: 8];
    wire [39:0] snap_word = {24'h00_0000, l3_type};
    wire [7:0]  snap_byte = snap_word[8*(4 - idx_ff[2:0]) +: 8];

    // IPv4 header; addresses belong to a later stage and go out as zero here
    wire [15:0] ip_w0   = {IP_VER_IHL, ipa_ff[7:0]};
    // Time to live goes first on the wire, protocol second
    wire [15:0] ip_w4   = {ipb_ff[23:16], ipb_ff[31:24]};
    wire [19:0] csum_a  = 20'(ip_w0) + 20'(total_ff) + 20'(id_ff) + 20'(ip_w4);
    wire [16:0] csum_b  = 17'(csum_a[15:0]) + 17'(csum_a[19:16]);
    wire [16:0] csum_c  = 17'(csum_b[15:0]) + 17'(csum_b[16]);
    wire [15:0] ip_csum = ~csum_c[15:0];
    wire [159:0] ip_vec = {ip_w0, total_ff, id_ff, 16'h0000, ip_w4, ip_csum, 64'h0};
    wire [7:0]  ip_byte = ip_vec[8*(19 - idx_ff) +: 8];

    // Sequencing
    wire vhb_state_type after_snap = is_ip4 ? ST_IP : ST_IDLE;
    wire vhb_state_type after_llc  = cfg_snap ? ST_SNAP : after_snap;
    wire vhb_state_type after_vlan = cfg_llc ? ST_LLC : after_snap;
    wire tag_step = (st_ff == ST_VLAN) && (idx_ff == 5'd3) && (tag_ff != last_tag);
    logic sec_end;
    logic [7:0] cur_byte;

    always_comb
    begin
        next_sec = ST_IDLE;
        sec_end  = 1'b0;
        cur_byte = 8'h00;
        unique case (st_ff)
            ST_IDLE: ;
            ST_VLAN:
            begin
                next_sec = after_vlan;
                sec_end  = (idx_ff == 5'd3) && (tag_ff == last_tag);
                cur_byte = vlan_byte;
            end
            ST_LLC:
            begin
                next_sec = after_llc;
                sec_end  = (idx_ff == 5'd2);
                cur_byte = llc_byte;
            end
            ST_SNAP:
            begin
                next_sec = after_snap;
                sec_end  = (idx_ff == 5'd4);
                cur_byte = snap_byte;
            end
            ST_IP:
            begin
                sec_end  = (idx_ff == 5'd19);
                cur_byte = ip_byte;
            end
        endcase
    end

    wire fifo_in_valid = busy;
    wire is_last       = sec_end && (next_sec == ST_IDLE);
    wire frame_end     = fifo_in_valid && fifo_in_ready && is_last;
    wire vhb_beat_type fifo_in = '{last: is_last, data: cur_byte};

    always_comb
    begin
        nxt_st  = st_ff;
        nxt_idx = idx_ff;
        nxt_tag = tag_ff;
        if (!busy)
        begin
            if (go)
            begin
                nxt_st  = ST_VLAN;
                // Without tags only the innermost type field is sent
                nxt_idx = (eff_cnt == 4'h0) ? 5'd2 : 5'd0;
                nxt_tag = 3'h0;
            end
        end
        else if (fifo_in_ready)
        begin
            if (sec_end)
            begin
                nxt_st  = next_sec;
                nxt_idx = 5'd0;
            end
            else if (tag_step)
            begin
                nxt_idx = 5'd0;
                nxt_tag = tag_ff + 3'h1;
            end
            else
            begin
                nxt_idx = idx_ff + 5'd1;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            st_ff  <= ST_IDLE;
            idx_ff <= 5'd0;
            tag_ff <= 3'h0;
        end
        else
        begin
            st_ff  <= nxt_st;
            idx_ff <= nxt_idx;
            tag_ff <= nxt_tag;
        end
    end

    // Identification and length snapshot
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            id_ff    <= IPA_RST[31:16];
            total_ff <= 16'h0000;
        end
        else if (go)
        begin
            total_ff <= ip_total;
            id_ff    <= cfg_idinc ? id_ff : ipa_ff[31:16];
        end
        else if (frame_end && cfg_idinc)
        begin
            id_ff <= id_ff + 16'h0001;
        end
        else if (cfg_wr && (byte_addr == OFS_IPA) && avs_byteenable[3:2] != 2'b00)
        begin
            id_ff <= (ipa_ff[31:16] & ~be_mask[31:16]) | wd_m[31:16];
        end
    end

    // Registers
    function automatic logic [31:0] merge(input logic [31:0] old);
        merge = (old & ~be_mask) | wd_m;
    endfunction

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            ctrl_ff <= CTRL_RST;
            type_ff <= TYPE_RST;
            ipa_ff  <= IPA_RST;
            ipb_ff  <= IPB_RST;
        end
        else if (cfg_wr)
        begin
            if (byte_addr == OFS_CTRL)
                ctrl_ff <= merge(ctrl_ff) & ~32'h0000_0001;
            if (byte_addr == OFS_TYPE)
                type_ff <= 16'(merge({16'h0000, type_ff}));
            if (byte_addr == OFS_IPA)
                ipa_ff <= merge(ipa_ff);
            if (byte_addr == OFS_IPB)
                ipb_ff <= merge(ipb_ff);
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < VHB_MAX_TAGS; gi++)
        begin : g_tag
            always_ff @(posedge core_clk)
            begin
                if (reset)
                    vlan_ff[gi] <= VLAN_RST;
                else if (cfg_wr && sel_vlan && (vidx == 3'(gi)))
                    vlan_ff[gi] <= 18'(merge({14'h0000, vlan_ff[gi]}));
            end
        end
    endgenerate

    wire [31:0] status_w = {id_ff, 8'h00, eff_cnt, 1'b0, start_rej_ff, cfg_err, busy};
    wire [31:0] rd_mux   = (byte_addr == OFS_CTRL)   ? ctrl_ff :
                           (byte_addr == OFS_STATUS) ? status_w :
                           (byte_addr == OFS_TYPE)   ? {16'h0000, type_ff} :
                           (byte_addr == OFS_IPA)    ? ipa_ff :
                           (byte_addr == OFS_IPB)    ? ipb_ff :
                           sel_vlan                  ? {14'h0000, vlan_ff[vidx]} : 32'h0000_0000;

    // Bus handshake and status-side flops
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            wait_ff        <= 1'b1;
            rdata_ff       <= 32'h0000_0000;
            start_pend_ff  <= 1'b0;
            start_rej_ff   <= 1'b0;
            first_tpid_ff  <= TPID_8100;
            tagged_only_ff <= 1'b0;
            busy_ff        <= 1'b0;
        end
        else
        begin
            wait_ff        <= !(req && wait_ff);
            rdata_ff       <= (avs_read && wait_ff) ? rd_mux : rdata_ff;
            start_pend_ff  <= start_req;
            start_rej_ff   <= start_pend_ff ? cfg_err : start_rej_ff;
            first_tpid_ff  <= (eff_cnt == 4'h2) ? TPID_88A8 : TPID_8100;
            tagged_only_ff <= (eff_cnt != 4'h0);
            busy_ff        <= (nxt_st != ST_IDLE);
        end
    end

    vhb_fifo #(
        .WIDTH (9),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .reset     (reset),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in),
        .out_valid (tx_valid),
        .out_ready (tx_ready),
        .out_data  (fifo_out)
    );

    assign tx_data         = fifo_out.data;
    assign tx_last         = fifo_out.last;
    assign avs_readdata    = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign first_tpid      = first_tpid_ff;
    assign rx_tagged_only  = tagged_only_ff;
    assign hdr_busy        = busy_ff;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // Receiver-style check: the emitted words, checksum included, fold to all ones
    wire [19:0] ip_sum_a = 20'(ip_vec[159:144]) + 20'(ip_vec[143:128]) + 20'(ip_vec[127:112])
                         + 20'(ip_vec[95:80]) + 20'(ip_vec[79:64]);
    wire [16:0] ip_sum_b = 17'(ip_sum_a[15:0]) + 17'(ip_sum_a[19:16]);
    wire [15:0] ip_sum_c = ip_sum_b[15:0] + 16'(ip_sum_b[16]);

    a_depth_cap_all: assert property (eff_cnt <= 4'h8)
        else $error("tag depth above eight");
    a_depth_cap_ping: assert property (cfg_ping |-> eff_cnt <= 4'h2)
        else $error("ping tag depth above two");
    a_outer_svc_tpid: assert property (##1 first_tpid_ff == (($past(eff_cnt) == 4'h2) ? TPID_88A8 : TPID_8100))
        else $error("outer tag TPID wrong");
    a_inner_ip_type: assert property ((st_ff == ST_VLAN) && (tag_ff == last_tag) && (idx_ff == 5'd2)
                                      && is_ip4 && !cfg_llc |-> cur_byte == 8'h08)
        else $error("innermost type not IPv4");
    a_llc_ctrl_ui: assert property ((st_ff == ST_LLC) && (idx_ff == 5'd2) |-> cur_byte == LLC_CTRL_UI)
        else $error("LLC control byte wrong");
    a_snap_oui_zero: assert property ((st_ff == ST_SNAP) && (idx_ff < 5'd3) |-> cur_byte == 8'h00)
        else $error("SNAP protocol id not zero");
    a_snap_needs_llc: assert property ((st_ff == ST_SNAP) |-> cfg_llc && $past(st_ff) != ST_VLAN)
        else $error("SNAP emitted without LLC");
    a_ip_ver_ihl: assert property ((st_ff == ST_IP) && (idx_ff == 5'd0) |-> cur_byte == 8'h45)
        else $error("IPv4 version or length wrong");
    a_total_len_calc: assert property (go |=> total_ff == 16'(IP_HDR_BYTES + ipb_ff[15:0]))
        else $error("total length not computed");
    a_id_auto_step: assert property (frame_end && cfg_idinc |=> id_ff == 16'($past(id_ff) + 16'h1))
        else $error("identification did not step");
    a_tagged_only: assert property ((eff_cnt != 4'h0) |=> rx_tagged_only)
        else $error("tagged-only not signalled");
    a_ip_checksum: assert property ((st_ff == ST_IP) |-> ip_sum_c == 16'hFFFF)
        else $error("IPv4 checksum does not fold to all ones");
    a_wait_one_low: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low twice");

    c_frame_done: cover property (frame_end);
    c_snap_frame: cover property ((st_ff == ST_SNAP) ##[1:40] frame_end);
    c_eight_tags: cover property (go && eff_cnt == 4'h8);
    c_start_reject: cover property (start_pend_ff && cfg_err);
    c_fifo_stall: cover property (busy && !fifo_in_ready);

endmodule // vhb_header_builder

`default_nettype wire

// ---- testbench/vhb_link_sink.sv ----
`timescale 1ns/1ns
`default_nettype none

module vhb_link_sink
(
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_last,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    input  wire logic [1:0] mode
);
    logic [7:0] got_q[$];
    int         last_at = -1;
    int         tick = 0;

    // Slow mode takes a byte one cycle in three; stop mode refuses all so the buffer fills
    always @(posedge core_clk)
    begin
        tick <= tick + 1;
        tx_ready <= !reset && (mode == 2'h0 || (mode == 2'h1 && tick % 3 == 0));
        if (!reset && tx_valid && tx_ready)
        begin
            got_q.push_back(tx_data);
            if (tx_last)
                last_at = got_q.size() - 1;
        end
    end
endmodule // vhb_link_sink

`default_nettype wire

// ---- testbench/test_vhb_header_builder.sv ----
`timescale 1ns/1ns
`default_nettype none

module test_vhb_header_builder;
    import vhb_pkg::*;
    logic        core_clk, reset, avs_read, avs_write, tx_last, tx_valid, tx_ready;
    logic        rx_tagged_only, hdr_busy, avs_waitrequest;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd_q;
    logic [7:0]  tx_data, tos;
    logic [15:0] first_tpid, typ, idv;
    logic [1:0]  mode;
    logic [3:0]  cnt;
    logic        l3, llc, snap, inc, v6 = 1'b0;
    logic [17:0] tag[8] = '{default: 18'h0};
    logic [7:0]  exp_q[$];
    int          errors = 0;
    int          checked = 0;
    int          cyc = 0;

    vhb_header_builder vhb_header_builder_inst (.core_clk(core_clk), .reset(reset),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .tx_data(tx_data), .tx_last(tx_last),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .first_tpid(first_tpid),
        .rx_tagged_only(rx_tagged_only), .hdr_busy(hdr_busy));
    vhb_link_sink vhb_link_sink_inst (.core_clk(core_clk), .reset(reset), .tx_data(tx_data),
        .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready), .mode(mode));

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task wrap_up;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            errors = errors + 1;
            wrap_up;
        end
    end

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
        checked++;
        if (seen !== ex)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, seen);
        end
    endtask

    // One edge passes after release so a following request never lands in the same step
    task bus(input logic w, input logic [5:0] ofs, input logic [31:0] d);
        avs_address <= ofs[5:2];
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge core_clk);
        rd_q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask

    task rd(input logic [5:0] ofs, input logic [31:0] ex, input string nm);
        bus(1'b0, ofs, 32'h0);
        chk(nm, rd_q, ex);
    endtask

    function logic [15:0] tp(input logic [1:0] s);
        return s == 2'h0 ? TPID_8100 : s == 2'h1 ? TPID_88A8 : s == 2'h2 ? TPID_9100 : TPID_9200;
    endfunction

    task push16(input logic [15:0] v);
        exp_q.push_back(v[15:8]);
        exp_q.push_back(v[7:0]);
    endtask

    task build;
        logic [15:0] w[10];
        logic [31:0] s;
        exp_q.delete();
        for (int k = 0; k < cnt; k++)
        begin
            push16({tag[k][14:12], tag[k][15], tag[k][11:0]});
            if (k < cnt - 1)
                push16(cnt == 4'h2 ? TPID_8100 : tp(tag[k][17:16]));
        end
        push16(llc ? 16'h3 + (snap ? 16'h5 : 16'h0) + (l3 ? 16'h3A : 16'h26)
                   : (l3 ? ETYPE_IPV4 : v6 ? ETYPE_IPV6 : typ));
        if (llc)
            push16({2{snap ? SAP_SNAP : (l3 ? SAP_IPV4 : SAP_OTHER)}});
        if (llc)
            exp_q.push_back(LLC_CTRL_UI);
        if (snap)
            push16({16'h0});
        if (snap)
            exp_q.push_back(8'h00);
        if (snap)
            push16(l3 ? ETYPE_IPV4 : v6 ? ETYPE_IPV6 : typ);
        w = '{{IP_VER_IHL, tos}, 16'h3A, idv, 16'h0, 16'h20FD, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
        s = 32'h0;
        foreach (w[i]) s += w[i];
        s = s[15:0] + s[31:16];
        s = s[15:0] + s[31:16];
        w[5] = ~s[15:0];
        if (l3)
            foreach (w[i]) push16(w[i]);
    endtask

    task run(input logic [1:0] m);
        build;
        vhb_link_sink_inst.got_q.delete();
        vhb_link_sink_inst.last_at = -1;
        mode <= m;
        bus(1'b1, OFS_CTRL, {20'h0, cnt, 1'b0, inc, v6, l3, snap, llc, 2'h1});
        if (m == 2'h2)
        begin
            repeat (100) @(posedge core_clk);
            chk("busy", hdr_busy, 1'b1);
            bus(1'b1, OFS_TYPE, 32'h1111);
            mode <= 2'h0;
        end
        while (vhb_link_sink_inst.last_at < 0 || hdr_busy !== 1'b0)
            @(posedge core_clk);
        chk("length", vhb_link_sink_inst.got_q.size(), exp_q.size());
        chk("last", vhb_link_sink_inst.last_at, exp_q.size() - 1);
        foreach (exp_q[i]) chk("byte", vhb_link_sink_inst.got_q[i], exp_q[i]);
    endtask

    initial
    begin
        reset = 1'b1;
        {avs_address, avs_read, avs_write, avs_writedata, mode} = '0;
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        chk("tpid", first_tpid, TPID_8100);
        chk("tagged", rx_tagged_only, 1'b0);
        rd(OFS_TYPE, TYPE_RST, "type");
        rd(OFS_IPB, IPB_RST, "ipb");
        rd(OFS_VLAN0, VLAN_RST, "vlan");
        bus(1'b1, 6'h14, 32'hFFFF_FFFF);
        rd(6'h14, 32'h0, "gap");
        bus(1'b1, OFS_CTRL, 32'h0502);
        rd(OFS_STATUS, 32'h20, "ping");
        bus(1'b1, OFS_CTRL, 32'h0F00);
        rd(OFS_STATUS, 32'h80, "clamp");
        bus(1'b1, OFS_CTRL, 32'h0009);
        rd(OFS_STATUS, 32'h6, "reject");
        bus(1'b1, OFS_CTRL, 32'h0031);
        rd(OFS_STATUS, 32'h6, "l3bad");
        chk("none", vhb_link_sink_inst.got_q.size(), 0);
        for (int k = 0; k < 4; k++)
        begin
            tag[k] = {2'(3 - k), k[0], 3'(k + 1), 12'(16'h100 * k + 16'h10 + k)};
            bus(1'b1, OFS_VLAN0 + 6'(4 * k), {14'h0, tag[k]});
        end
        {cnt, l3, llc, snap, inc, typ, tos, idv} = {4'h4, 4'b0110, 16'h05DD, 8'h0, 16'h0};
        bus(1'b1, OFS_TYPE, {16'h0, typ});
        run(2'h1);
        chk("tagged", rx_tagged_only, 1'b1);
        {cnt, l3, llc, snap, inc, tos, idv} = {4'h2, 4'b1000, 8'hB8, 16'h1234};
        bus(1'b1, OFS_IPA, {idv, 8'h0, tos});
        run(2'h0);
        chk("tpid", first_tpid, TPID_88A8);
        inc = 1'b1;
        run(2'h0);
        {cnt, llc, idv} = {4'h8, 1'b1, 16'h1235};
        run(2'h2);
        rd(OFS_TYPE, {16'h0, typ}, "dropped");
        {cnt, v6, l3, llc} = {4'h1, 3'b100};
        run(2'h0);
        {cnt, v6} = {4'h0, 1'b0};
        run(2'h0);
        chk("tagged", rx_tagged_only, 1'b0);
        wrap_up;
    end
endmodule // test_vhb_header_builder

`default_nettype wire
